// File: fpg_cfg.svh
// Constants for the flash protection and data-flash gate.
// Assumes a 100 MHz system clock; included by every file except the package and the host model.
//
// Summary of operation
// RULE_01 - Self-programming block erase outside the shield window is rejected.
// RULE_02 - Self-programming write outside the window is rejected; inside it is accepted.
// RULE_03 - Serial programming ignores the window for erase and write.
// RULE_04 - Erase prohibition refuses serial erase; serial write and self erase still allowed.
// RULE_05 - Write prohibition refuses serial writes; serial erase and self writes still allowed.
// RULE_06 - Boot cluster prohibition refuses erase and write to 00000H-00FFFH always.
// RULE_07 - All three prohibitions are clear in the shipped state.
// RULE_08 - Each prohibition is set independently from either programming mode.
// RULE_09 - Erase and boot cluster prohibitions are permanent once set.
// RULE_10 - Write prohibition released only serially, other two clear, flash blank.
// RULE_11 - A release after a write-prohibition setting takes effect only after reset.
// RULE_12 - Data flash erase works on whole 1-Kbyte blocks.
// RULE_13 - Data flash is reached only by byte-wide reads and writes.
// RULE_14 - No instruction fetch from data flash; code fetch continues during its rewrite.
// RULE_15 - Data flash access is blocked during self-programmed code rewrite.
// RULE_16 - During data flash rewrite control register writes and stop entry are refused.
// RULE_17 - Control register resets to 00H, data flash stopped.
// RULE_18 - Bit 0 enables data flash; bits 7 to 1 read zero; bit or byte writes.
// RULE_19 - Data flash stays inaccessible for setup time after enable: 5 us or 720 ns.
// RULE_20 - Software clears enable before stopping while setup still runs.
// RULE_21 - After subclock reads, one dummy read then 5 us or 1 us wait.
// RULE_22 - Boot cluster prohibition beats the window; window covers code flash only.
// RULE_23 - A mode input selects serial or self-programming checks.
`ifndef FPG_CFG_SVH
`define FPG_CFG_SVH
`define FPG_CTL_ADDR 20'hF0090
`define FPG_CTL_RESET 8'h00
`define FPG_EN_BIT 0
`define FPG_BOOT0_LAST 20'h00FFF
`define FPG_DF_BLOCK_SHIFT 10
`define FPG_CLK_MHZ 100
`define FPG_SETUP_HS_NS 5000
`define FPG_SETUP_LS_NS 720
`define FPG_DUMMY_HS_NS 5000
`define FPG_DUMMY_LS_NS 1000
`define FPG_NS_PER_S 1000
// Least times round up to whole cycles
`define FPG_CYC(ns) (((ns) * `FPG_CLK_MHZ + `FPG_NS_PER_S - 1) / `FPG_NS_PER_S)
`define FPG_CNT_W 10
`endif

// File: fpg_pkg.sv
// Types shared by the flash protection and data-flash gate modules.
// Uses no fpg_cfg.svh constants; its enum encodings are given as literals.
package fpg_pkg;
    typedef enum logic [1:0] {
        FPG_OP_ERASE = 2'b01,
        FPG_OP_WRITE = 2'b10
    } fpg_op_t;
    typedef enum logic [2:0] {
        FPG_GATE_OFF = 3'b001,
        FPG_GATE_WAIT = 3'b010,
        FPG_GATE_READY = 3'b100
    } fpg_gate_t;
endpackage

// File: fpg_tmr_if.sv
// Carrier between the gate and its setup timer.
// Assumes one clock domain shared by both ends.
`include "fpg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
interface fpg_tmr_if;
    logic start;
    logic [`FPG_CNT_W-1:0] load;
    logic abort;
    logic done;
    modport ctl (output start, output load, output abort, input done);
    modport tmr (input start, input load, input abort, output done);
endinterface
`default_nettype wire

// File: fpg_timer.sv
// Down counter timing setup and post-switch waits.
// Assumes loads of at least one cycle from the controlling module.
`include "fpg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fpg_timer (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, high
    fpg_tmr_if.tmr tmr // Start, load and done
);
    typedef struct packed {
        logic [`FPG_CNT_W-1:0] count;
        logic busy;
    } fpg_tmr_state_t;
    fpg_tmr_state_t st_r;
    fpg_tmr_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (tmr.abort) begin
            st_nxt.busy = 1'b0;
            st_nxt.count = '0;
        end else if (tmr.start) begin
            st_nxt.busy = 1'b1;
            st_nxt.count = tmr.load;
        end else if (st_r.busy) begin
            if (st_r.count <= `FPG_CNT_W'(1)) begin
                st_nxt.busy = 1'b0;
            end
            st_nxt.count = st_r.count - `FPG_CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tmr.done = st_r.busy && (st_r.count <= `FPG_CNT_W'(1)) && !tmr.start && !tmr.abort;
endmodule // fpg_timer
`default_nettype wire

// File: fpg_gate.sv
// Flash protection checker, security flags and data-flash access gate.
// Assumes the flash sequencer reports blank status and rewrite activity,
// and that the CPU bus presents one request per cycle.
`include "fpg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fpg_gate
    import fpg_pkg::*;
#(
    parameter int ADDR_W = 20,
    parameter int BLOCK_W = 8,
    parameter int BLOCK_SHIFT = 10
) (
    input wire logic clk, // System clock
    input wire logic reset, // Synchronous reset, high
    input wire logic serialMode, // 1 serial programming, 0 self-programming
    input wire logic cmdValid, // Code flash command strobe
    input wire fpg_op_t cmdOp, // Erase or write
    input wire logic [ADDR_W-1:0] cmdAddr, // Target byte address
    input wire logic [BLOCK_W-1:0] windowStart, // Shield window first block
    input wire logic [BLOCK_W-1:0] windowEnd, // Shield window last block
    output logic cmdAccept, // Command allowed
    output logic cmdReject, // Command refused
    input wire logic secSetValid, // Security set command strobe
    input wire logic [2:0] secSetMask, // Bit0 erase, bit1 write, bit2 boot
    input wire logic secRelValid, // Write-prohibition release strobe
    input wire logic codeBlank, // Code flash area blank
    input wire logic dataBlank, // Data flash area blank
    output logic [2:0] secFlags, // Active prohibitions
    output logic secRelPending, // Release waits for reset
    input wire logic codeRewriteBusy, // Self-programmed code rewrite running
    input wire logic dataRewriteBusy, // Data flash rewrite running
    input wire logic highSpeedMainMode, // 1 high-speed main, 0 low-speed main
    input wire logic cpuClockSourceSelect, // 1 subsystem clock
    input wire logic regWrite, // Register write strobe
    input wire logic regRead, // Register read strobe
    input wire logic regBitOp, // Single bit manipulation
    input wire logic [2:0] regBitSel, // Bit index for bit op
    input wire logic [ADDR_W-1:0] regAddr, // Register address
    input wire logic [7:0] regWdata, // Write data
    output logic [7:0] regRdata, // Read data
    input wire logic dfReq, // Data flash access request
    input wire logic dfFetch, // Request is an instruction fetch
    input wire logic [1:0] dfSize, // Transfer size, 0 means byte
    input wire logic [ADDR_W-1:0] dfAddr, // Data flash byte address
    input wire logic dfEraseReq, // Data flash erase request
    output logic dfGrant, // Access passed to array
    output logic dfDeny, // Access refused
    output logic dfReadUndefined, // Granted read returns undefined data
    output logic [ADDR_W-1:0] dfEraseBase, // Erase block base address
    output logic dfEraseGo, // Erase passed to array
    input wire logic stopReq, // Stop instruction request
    output logic stopAccept, // Stop mode may be entered
    output logic codeFetchAllowed // Code fetch may proceed
);
    localparam int SEC_ERASE = 0;
    localparam int SEC_WRITE = 1;
    localparam int SEC_BOOT = 2;

    if (BLOCK_SHIFT + BLOCK_W < ADDR_W - 8 || BLOCK_SHIFT >= ADDR_W) begin : g_bad_geom
        $error("fpg_gate: block geometry does not fit the address width");
    end

    typedef struct packed {
        logic [2:0] sec;
        logic relArmed;
        logic enable;
        fpg_gate_t gate;
        logic subRead;
        logic dummyDue;
        logic accept;
        logic reject;
        logic grant;
        logic deny;
        logic undef;
        logic eraseGo;
        logic [ADDR_W-1:0] eraseBase;
        logic [7:0] rdata;
    } fpg_state_t;
    // Shipped state: flags start clear at time zero; erase and boot kept across reset, write kept unless a release is armed
    fpg_state_t st_r = '0; // see RULE_07
    fpg_state_t st_nxt;

    fpg_tmr_if tmrBus();

    fpg_timer u_timer (
        .clk(clk),
        .reset(reset),
        .tmr(tmrBus.tmr)
    );

    function automatic logic inBoot(input logic [ADDR_W-1:0] a);
        return a <= ADDR_W'(`FPG_BOOT0_LAST);
    endfunction

    function automatic logic [BLOCK_W-1:0] blockOf(input logic [ADDR_W-1:0] a);
        return BLOCK_W'(a >> BLOCK_SHIFT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Code flash command check

    logic cmdOk;
    logic inWin;
    logic ctlHit;
    logic [7:0] wval;
    always_comb begin
        inWin = (blockOf(cmdAddr) >= windowStart) && (blockOf(cmdAddr) <= windowEnd);
        cmdOk = 1'b1;
        if (!serialMode && !inWin) begin
            cmdOk = 1'b0; // see RULE_01 see RULE_02 see RULE_03 see RULE_23
        end
        if (serialMode && cmdOp == FPG_OP_ERASE && st_r.sec[SEC_ERASE]) begin
            cmdOk = 1'b0; // see RULE_04
        end
        if (serialMode && cmdOp == FPG_OP_WRITE && st_r.sec[SEC_WRITE]) begin
            cmdOk = 1'b0; // see RULE_05
        end
        // Boot cluster guard checked last so it overrides the window
        if (st_r.sec[SEC_BOOT] && inBoot(cmdAddr)) begin
            cmdOk = 1'b0; // see RULE_06 see RULE_22
        end
        ctlHit = regWrite && (regAddr == ADDR_W'(`FPG_CTL_ADDR));
        wval = {7'h00, st_r.enable};
        if (regBitOp) begin
            wval[regBitSel] = regWdata[0];
        end else begin
            wval = regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    logic dfBlocked;
    logic [`FPG_CNT_W-1:0] setupCyc;
    logic [`FPG_CNT_W-1:0] dummyCyc;
    always_comb begin
        setupCyc = highSpeedMainMode ? `FPG_CNT_W'(`FPG_CYC(`FPG_SETUP_HS_NS))
                                     : `FPG_CNT_W'(`FPG_CYC(`FPG_SETUP_LS_NS));
        dummyCyc = highSpeedMainMode ? `FPG_CNT_W'(`FPG_CYC(`FPG_DUMMY_HS_NS))
                                     : `FPG_CNT_W'(`FPG_CYC(`FPG_DUMMY_LS_NS));
        st_nxt = st_r;
        st_nxt.accept = 1'b0;
        st_nxt.reject = 1'b0;
        st_nxt.grant = 1'b0;
        st_nxt.deny = 1'b0;
        st_nxt.undef = 1'b0;
        st_nxt.eraseGo = 1'b0;
        tmrBus.start = 1'b0;
        tmrBus.load = setupCyc;
        tmrBus.abort = 1'b0;

        if (cmdValid) begin
            st_nxt.accept = cmdOk;
            st_nxt.reject = !cmdOk;
        end

        // Flags only ever set here; no path clears erase or boot
        if (secSetValid) begin
            st_nxt.sec = st_r.sec | secSetMask; // see RULE_08 see RULE_09
            if (secSetMask[SEC_WRITE]) begin
                st_nxt.relArmed = 1'b0;
            end
        end else if (secRelValid && serialMode && !st_r.sec[SEC_ERASE]
                     && !st_r.sec[SEC_BOOT] && codeBlank && dataBlank) begin
            // Release armed now, applied at the next reset
            st_nxt.relArmed = st_r.sec[SEC_WRITE]; // see RULE_10 see RULE_11
        end

        // Control register; frozen while the data flash is rewritten
        if (ctlHit && !dataRewriteBusy) begin // see RULE_16
            st_nxt.enable = wval[`FPG_EN_BIT]; // see RULE_18
        end
        if (regRead) begin
            st_nxt.rdata = (regAddr == ADDR_W'(`FPG_CTL_ADDR))
                         ? {7'h00, st_r.enable} : 8'h00; // see RULE_18
        end

        case (st_r.gate)
            FPG_GATE_OFF: begin
                if (st_nxt.enable) begin
                    st_nxt.gate = FPG_GATE_WAIT;
                    tmrBus.start = 1'b1; // see RULE_19
                end
            end
            FPG_GATE_WAIT: begin
                if (!st_nxt.enable) begin
                    st_nxt.gate = FPG_GATE_OFF;
                    tmrBus.abort = 1'b1; // see RULE_20
                end else if (tmrBus.done) begin
                    st_nxt.gate = FPG_GATE_READY;
                end
            end
            FPG_GATE_READY: begin
                if (!st_nxt.enable) begin
                    st_nxt.gate = FPG_GATE_OFF;
                end
            end
            default: begin
                st_nxt.gate = FPG_GATE_OFF;
            end
        endcase

        dfBlocked = st_r.gate != FPG_GATE_READY || codeRewriteBusy; // see RULE_15
        if (dfReq) begin
            if (dfBlocked || dfFetch || dfSize != 2'b00) begin
                st_nxt.deny = 1'b1; // see RULE_13 see RULE_14
            end else if (st_r.dummyDue) begin
                // First read after the clock switch is a throwaway
                st_nxt.grant = 1'b1; // see RULE_21
                st_nxt.undef = 1'b1;
                st_nxt.dummyDue = 1'b0;
                st_nxt.gate = FPG_GATE_WAIT;
                tmrBus.start = 1'b1;
                tmrBus.load = dummyCyc;
            end else begin
                st_nxt.grant = 1'b1;
                if (cpuClockSourceSelect) begin
                    st_nxt.subRead = 1'b1;
                end
            end
        end
        if (st_r.subRead && !cpuClockSourceSelect) begin
            st_nxt.subRead = 1'b0;
            st_nxt.dummyDue = 1'b1;
        end

        if (dfEraseReq && !dfBlocked) begin
            st_nxt.eraseGo = 1'b1;
            st_nxt.eraseBase = (dfAddr >> `FPG_DF_BLOCK_SHIFT) << `FPG_DF_BLOCK_SHIFT; // see RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (reset) begin
            // Armed write release takes effect here
            st_r.sec[SEC_WRITE] <= st_r.sec[SEC_WRITE] & ~st_r.relArmed; // see RULE_11
            st_r.sec[SEC_ERASE] <= st_r.sec[SEC_ERASE];
            st_r.sec[SEC_BOOT] <= st_r.sec[SEC_BOOT];
            st_r.relArmed <= 1'b0;
            st_r.enable <= 1'(`FPG_CTL_RESET); // see RULE_17
            st_r.gate <= FPG_GATE_OFF;
            st_r.subRead <= 1'b0;
            st_r.dummyDue <= 1'b0;
            st_r.accept <= 1'b0;
            st_r.reject <= 1'b0;
            st_r.grant <= 1'b0;
            st_r.deny <= 1'b0;
            st_r.undef <= 1'b0;
            st_r.eraseGo <= 1'b0;
            st_r.eraseBase <= '0;
            st_r.rdata <= `FPG_CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign cmdAccept = st_r.accept;
    assign cmdReject = st_r.reject;
    assign secFlags = st_r.sec;
    assign secRelPending = st_r.relArmed;
    assign regRdata = st_r.rdata;
    assign dfGrant = st_r.grant;
    assign dfDeny = st_r.deny;
    assign dfReadUndefined = st_r.undef;
    assign dfEraseBase = st_r.eraseBase;
    assign dfEraseGo = st_r.eraseGo;
    assign stopAccept = stopReq && !dataRewriteBusy && st_r.gate != FPG_GATE_WAIT; // see RULE_16
    assign codeFetchAllowed = !codeRewriteBusy || serialMode; // see RULE_14
endmodule // fpg_gate
`default_nettype wire

// File: fpg_gate_chk.sv
// Concurrent checks on the flash gate's top-level ports.
// Assumes one clock and a synchronous active-high reset.
`include "fpg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fpg_gate_chk
    import fpg_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic serialMode, // Mode
    input wire logic cmdValid, // Command
    input wire fpg_op_t cmdOp, // Operation
    input wire logic [ADDR_W-1:0] cmdAddr, // Target
    input wire logic cmdAccept, // Accepted
    input wire logic cmdReject, // Refused
    input wire logic [2:0] secFlags, // Prohibitions
    input wire logic dataRewriteBusy, // Data rewrite
    input wire logic regWrite, // Reg write
    input wire logic regBitOp, // Bit op
    input wire logic [ADDR_W-1:0] regAddr, // Reg address
    input wire logic [7:0] regWdata, // Write data
    input wire logic dfReq, // Access
    input wire logic dfFetch, // Fetch
    input wire logic [1:0] dfSize, // Size
    input wire logic dfGrant, // Granted
    input wire logic dfDeny, // Denied
    input wire logic dfReadUndefined, // Undefined read
    input wire logic stopAccept // Stop allowed
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////////////
    one_answer_a: assert property (cmdValid |=> cmdAccept ^ cmdReject)
        else $error("command answer not unique");
    boot_guard_a: assert property (cmdValid && secFlags[2]
        && cmdAddr <= `FPG_BOOT0_LAST |=> cmdReject) else $error("boot cluster rewritten");
    erase_lock_a: assert property (cmdValid && serialMode && secFlags[0]
        && cmdOp == FPG_OP_ERASE |=> cmdReject) else $error("serial erase passed");
    write_lock_a: assert property (cmdValid && serialMode && secFlags[1]
        && cmdOp == FPG_OP_WRITE |=> cmdReject) else $error("serial write passed");
    // Erase and boot flags outlive reset; a drop of either is a fault, checked only while reset is low
    flag_sticky_a: assert property (($past(secFlags) & ~secFlags & 3'h5) == 3'h0)
        else $error("permanent flag cleared");
    fetch_deny_a: assert property (dfReq && dfFetch |=> dfDeny && !dfGrant)
        else $error("fetch from data flash");
    size_deny_a: assert property (dfReq && dfSize != 2'h0 |=> dfDeny && !dfGrant)
        else $error("wide data flash access");
    stop_hold_a: assert property (dataRewriteBusy |-> !stopAccept)
        else $error("stop during rewrite");
    setup_hold_a: assert property (regWrite && !regBitOp && regWdata[0]
        && regAddr == `FPG_CTL_ADDR && !dataRewriteBusy |=> !dfGrant [*8])
        else $error("grant inside setup");
    cover property (cmdValid ##1 cmdReject);
    cover property (dfReq ##1 dfGrant);
    cover property (dfReadUndefined);
endmodule // fpg_gate_chk
`default_nettype wire

// File: fpg_host.sv
// CPU model issuing register and data flash requests.
// Assumes answers arrive one cycle after the request edge.
`timescale 1ns/1ns
`default_nettype none
module fpg_host (
    input wire logic clk, // Clock
    output logic regWrite, // Reg write
    output logic regRead, // Reg read
    output logic regBitOp, // Bit op
    output logic [2:0] regBitSel, // Bit index
    output logic [19:0] regAddr, // Reg address
    output logic [7:0] regWdata, // Write data
    output logic dfReq, // Access
    output logic dfFetch, // Fetch
    output logic [1:0] dfSize, // Size
    output logic [19:0] dfAddr, // Address
    output logic dfEraseReq // Erase
);
    initial begin
        {regWrite, regRead, regBitOp, regBitSel, regAddr, regWdata} = '0;
        {dfReq, dfFetch, dfSize, dfAddr, dfEraseReq} = '0;
    end
    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic b,
        input logic [2:0] s);
        @(posedge clk);
        {regWrite, regAddr, regWdata, regBitOp, regBitSel} <= {1'b1, a, d, b, s};
        @(posedge clk);
        regWrite <= 1'b0;
        regWdata <= ~d; // Released data never holds its last value
        #1;
    endtask
    task automatic rd(input logic [19:0] a);
        @(posedge clk);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge clk);
        regRead <= 1'b0;
        #1;
    endtask
    task automatic acc(input logic f, input logic [1:0] sz, input logic [19:0] a,
        input logic er);
        @(posedge clk);
        {dfReq, dfEraseReq, dfFetch, dfSize, dfAddr} <= {~er, er, f, sz, a};
        @(posedge clk);
        {dfReq, dfEraseReq} <= 2'h0;
        dfAddr <= ~a;
        #1;
    endtask
    // Firmware waits out setup or post-switch time before real reads
    task automatic settle(input logic hs, input logic dummy);
        repeat (hs ? 505 : (dummy ? 105 : 75)) @(posedge clk);
    endtask
endmodule // fpg_host
`default_nettype wire

// File: fpg_gate_tb.sv
// Self-checking bench for the flash protection and data-flash gate.
// Assumes fpg_host drives the CPU bus and the bench drives the rest.
`include "fpg_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
bind fpg_gate fpg_gate_chk #(.ADDR_W(ADDR_W)) chk (.clk, .reset, .serialMode, .cmdValid,
    .cmdOp, .cmdAddr, .cmdAccept, .cmdReject, .secFlags, .dataRewriteBusy, .regWrite,
    .regBitOp, .regAddr, .regWdata, .dfReq, .dfFetch, .dfSize, .dfGrant, .dfDeny,
    .dfReadUndefined, .stopAccept);
module fpg_gate_tb;
    import fpg_pkg::*;
    localparam logic [19:0] CTL = `FPG_CTL_ADDR;
    logic clk, reset, serialMode, cmdValid, cmdAccept, cmdReject, secSetValid, secRelValid;
    logic codeBlank, dataBlank, secRelPending, codeRewriteBusy, dataRewriteBusy, stopReq;
    logic highSpeedMainMode, cpuClockSourceSelect, regWrite, regRead, regBitOp, dfReq;
    logic dfFetch, dfEraseReq, dfGrant, dfDeny, dfReadUndefined, dfEraseGo;
    logic stopAccept, codeFetchAllowed;
    logic [19:0] cmdAddr, regAddr, dfAddr, dfEraseBase;
    logic [7:0] windowStart, windowEnd, regWdata, regRdata;
    logic [2:0] secSetMask, secFlags, regBitSel;
    logic [1:0] dfSize;
    fpg_op_t cmdOp;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    fpg_gate dut (.clk, .reset, .serialMode, .cmdValid, .cmdOp, .cmdAddr, .windowStart,
        .windowEnd, .cmdAccept, .cmdReject, .secSetValid, .secSetMask, .secRelValid,
        .codeBlank, .dataBlank, .secFlags, .secRelPending, .codeRewriteBusy,
        .dataRewriteBusy, .highSpeedMainMode, .cpuClockSourceSelect, .regWrite, .regRead,
        .regBitOp, .regBitSel, .regAddr, .regWdata, .regRdata, .dfReq, .dfFetch, .dfSize,
        .dfAddr, .dfEraseReq, .dfGrant, .dfDeny, .dfReadUndefined, .dfEraseBase,
        .dfEraseGo, .stopReq, .stopAccept, .codeFetchAllowed);
    fpg_host host (.clk, .regWrite, .regRead, .regBitOp, .regBitSel, .regAddr, .regWdata,
        .dfReq, .dfFetch, .dfSize, .dfAddr, .dfEraseReq);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s exp %h got %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmd(input logic sm, input fpg_op_t op, input logic [19:0] a, input logic ok);
        @(posedge clk);
        {serialMode, cmdValid, cmdAddr} <= {sm, 1'b1, a};
        cmdOp <= op;
        @(posedge clk);
        cmdValid <= 1'b0;
        #1;
        chk("cmd answer", 20'({ok, ~ok}), 20'({cmdAccept, cmdReject}));
    endtask
    task automatic sec(input logic sm, input logic rel, input logic [2:0] m);
        @(posedge clk);
        {serialMode, secSetValid, secRelValid, secSetMask} <= {sm, ~rel, rel, m};
        @(posedge clk);
        {secSetValid, secRelValid} <= 2'h0;
        #1;
    endtask
    task automatic rst();
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_window();
        fpg_op_t op;
        for (int i = 0; i < 2; i++) begin
            op = (i == 1) ? FPG_OP_WRITE : FPG_OP_ERASE;
            cmd(1'b0, op, 20'h00FFF, 1'b0);
            cmd(1'b0, op, 20'h01000, 1'b1);
            cmd(1'b0, op, 20'h01BFF, 1'b1);
            cmd(1'b0, op, 20'h01C00, 1'b0);
            cmd(1'b1, op, 20'h01C00, 1'b1);
        end
        $display("test window done");
    endtask
    task automatic t_reg();
        host.rd(CTL);
        chk("ctl reset", 20'h00, 20'(regRdata));
        chk("flags reset", 20'h0, 20'(secFlags));
        host.wr(CTL, 8'hFF, 1'b0, 3'h0);
        host.rd(CTL);
        chk("ctl byte", 20'h01, 20'(regRdata));
        host.wr(CTL, 8'h01, 1'b1, 3'h3);
        host.wr(CTL, 8'h00, 1'b1, 3'h0);
        host.rd(CTL);
        chk("ctl bit", 20'h00, 20'(regRdata));
        host.rd(20'hF0091);
        chk("unmapped", 20'h00, 20'(regRdata));
        @(posedge clk);
        {dataRewriteBusy, stopReq} <= 2'h3;
        host.wr(CTL, 8'h01, 1'b0, 3'h0);
        host.rd(CTL);
        chk("ctl busy", 20'h00, 20'(regRdata));
        chk("stop busy", 20'h0, 20'(stopAccept));
        @(posedge clk);
        dataRewriteBusy <= 1'b0;
        host.wr(CTL, 8'h01, 1'b0, 3'h0);
        chk("stop setup", 20'h0, 20'(stopAccept));
        host.wr(CTL, 8'h00, 1'b0, 3'h0);
        chk("stop clear", 20'h1, 20'(stopAccept));
        @(posedge clk);
        stopReq <= 1'b0;
        $display("test reg done");
    endtask
    task automatic t_df();
        host.wr(CTL, 8'h01, 1'b0, 3'h0);
        host.acc(1'b0, 2'h0, 20'hF1000, 1'b0);
        chk("df early", 20'h1, 20'({dfGrant, dfDeny}));
        host.settle(1'b0, 1'b0);
        host.acc(1'b0, 2'h0, 20'hF1000, 1'b0);
        chk("df ready", 20'h2, 20'({dfGrant, dfDeny}));
        host.acc(1'b1, 2'h0, 20'hF1000, 1'b0);
        chk("df fetch", 20'h1, 20'({dfGrant, dfDeny}));
        host.acc(1'b0, 2'h1, 20'hF1000, 1'b0);
        chk("df word", 20'h1, 20'({dfGrant, dfDeny}));
        @(posedge clk);
        {codeRewriteBusy, dataRewriteBusy} <= 2'h1;
        host.acc(1'b0, 2'h0, 20'hF1000, 1'b0);
        chk("code fetch", 20'h1, 20'(codeFetchAllowed));
        @(posedge clk);
        {codeRewriteBusy, dataRewriteBusy} <= 2'h2;
        host.acc(1'b0, 2'h0, 20'hF1000, 1'b0);
        chk("df code busy", 20'h1, 20'({dfGrant, dfDeny}));
        @(posedge clk);
        codeRewriteBusy <= 1'b0;
        host.acc(1'b0, 2'h0, 20'hF17FF, 1'b1);
        chk("erase base", 20'hF1400, dfEraseGo ? dfEraseBase : 20'hFFFFF);
        @(posedge clk);
        cpuClockSourceSelect <= 1'b1;
        host.acc(1'b0, 2'h0, 20'hF1001, 1'b0);
        @(posedge clk);
        cpuClockSourceSelect <= 1'b0;
        host.acc(1'b0, 2'h0, 20'hF1001, 1'b0);
        chk("dummy read", 20'h3, 20'({dfGrant, dfReadUndefined}));
        host.settle(1'b0, 1'b1);
        host.acc(1'b0, 2'h0, 20'hF1001, 1'b0);
        chk("valid read", 20'h2, 20'({dfGrant, dfReadUndefined}));
        $display("test df done");
    endtask
    task automatic t_sec();
        sec(1'b1, 1'b0, 3'h2);
        chk("flags w", 20'h2, 20'(secFlags));
        cmd(1'b1, FPG_OP_WRITE, 20'h02000, 1'b0);
        cmd(1'b1, FPG_OP_ERASE, 20'h02000, 1'b1);
        cmd(1'b0, FPG_OP_WRITE, 20'h01000, 1'b1);
        sec(1'b0, 1'b1, 3'h0);
        chk("rel self", 20'h0, 20'(secRelPending));
        sec(1'b1, 1'b1, 3'h0);
        chk("rel armed", 20'h3, 20'({secRelPending, secFlags[1]}));
        rst();
        chk("rel done", 20'h0, 20'(secFlags));
        sec(1'b0, 1'b0, 3'h1);
        cmd(1'b1, FPG_OP_ERASE, 20'h02000, 1'b0);
        cmd(1'b1, FPG_OP_WRITE, 20'h02000, 1'b1);
        cmd(1'b0, FPG_OP_ERASE, 20'h01000, 1'b1);
        sec(1'b1, 1'b0, 3'h6);
        sec(1'b1, 1'b1, 3'h0);
        rst();
        chk("flags kept", 20'h7, 20'(secFlags));
        @(posedge clk);
        windowStart <= 8'h00;
        cmd(1'b0, FPG_OP_ERASE, 20'h00800, 1'b0);
        cmd(1'b1, FPG_OP_WRITE, 20'h00800, 1'b0);
        cmd(1'b0, FPG_OP_WRITE, 20'h01000, 1'b1);
        $display("test sec done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {reset, serialMode, cmdValid, secSetValid, secRelValid, stopReq} = 6'h20;
        {codeRewriteBusy, dataRewriteBusy, highSpeedMainMode, cpuClockSourceSelect} = 4'h0;
        {codeBlank, dataBlank} = 2'h3;
        {cmdAddr, windowStart, windowEnd, secSetMask} = {20'h00000, 8'h04, 8'h06, 3'h0};
        cmdOp = FPG_OP_ERASE;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_reg();
        t_window();
        t_df();
        t_sec();
        test_done();
    end
endmodule // fpg_gate_tb
`default_nettype wire
